// ==== hdl/snsid_params.svh ====
// snsid_params.svh: offsets, field positions, reset values and timing counts
// assumes: included by bare name from the design file and the test bench
`ifndef SNSID_PARAMS_SVH
`define SNSID_PARAMS_SVH
// ----------------------------------------------------------------------------
// register pointers
// ----------------------------------------------------------------------------
`define SNSID_PTR_TEMP      8'h00
`define SNSID_PTR_CONFIG    8'h01
`define SNSID_PTR_HIGH_LIM  8'h02
`define SNSID_PTR_LOW_LIM   8'h03
`define SNSID_PTR_UNLOCK    8'h04
`define SNSID_PTR_SCRATCH4  8'h08
`define SNSID_PTR_PART_ID   8'h0f
// ----------------------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------------------
`define SNSID_UNLOCK_BIT    15
`define SNSID_BUSY_BIT      14
`define SNSID_AVG_LSB       5
`define SNSID_CFG_RESET     16'h0220
`define SNSID_HIGH_RESET    16'h6000
`define SNSID_LOW_RESET     16'h8000
// arbitrary neutral part code, not any real product's value
`define SNSID_PART_CODE     12'h5a3
`define SNSID_BASE_ADDR     7'h48
// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define SNSID_CLK_MHZ       125
`define SNSID_NVM_PROG_US   7
`define SNSID_NVM_PROG_CYC  (`SNSID_NVM_PROG_US * `SNSID_CLK_MHZ)
`endif

// ==== hdl/snsid_pkg.sv ====
// snsid_pkg.sv: types shared by the sensor register bank
// assumes: compiled before the design module
package snsid_pkg;
   // two-wire target states
   typedef enum logic [2:0] {
      SNSID_IDLE, SNSID_ADDR, SNSID_ACK, SNSID_WRX, SNSID_RDX, SNSID_RACK
   } snsid_state_t;
   // averaging depth selection
   typedef enum logic [1:0] {
      SNSID_AVG_1, SNSID_AVG_8, SNSID_AVG_32, SNSID_AVG_64
   } snsid_avg_t;
endpackage : snsid_pkg

// ==== hdl/snsid_regs.sv ====
// snsid_regs.sv: two-wire target with scratch, part code, limits and alarm
// assumes: scl/sda sampled synchronously to clk; nvm_* connect to a backing store
//
// Summary of operation
// [RULE1] 16-bit scratch word at pointer 08h, all bits read and write.
// [RULE2] scratch word reloads from its nonvolatile copy, no fixed reset value; the code clears it to 0000h on arst_n until nvm_load.
// [RULE3] locked writes touch only the register; unlocked writes also program nvm; the code skips programming while the busy count runs.
// [RULE4] pointer 0Fh reads a fixed 12-bit part code, upper nibble unused.
// [RULE5] writes to the part code are acknowledged and ignored.
// [RULE6] target only, never drives scl nor starts a transfer.
// [RULE7] scl input, sda open-drain, alarm is an output.
// [RULE8] strap level picks one of four bus addresses.
// [RULE9] alarm fires when temperature crosses high or low limit.
// [RULE10] limits and temperature are 16-bit two's complement.
// [RULE11] averaging over 8, 32 or 64 samples is selectable.
`include "snsid_params.svh"
`timescale 1ns/1ps
`default_nettype none
module snsid_regs
   import snsid_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        arst_n,
   input  wire logic        scl_in,
   input  wire logic        sda_in,
   output logic             sda_out,
   output logic             sda_oe,
   input  wire logic [1:0]  address_strap_pin,
   input  wire logic [15:0] temp_result,
   input  wire logic        temp_valid,
   input  wire logic [15:0] nvm_scratch_data,
   input  wire logic        nvm_load,
   output logic             nvm_prog,
   output logic [15:0]      nvm_prog_data,
   output logic [1:0]       avg_sel,
   output logic             alarm_n
);
   // ----------------------------------------------------------------------------
   // bus edge detection
   // ----------------------------------------------------------------------------
   logic scl_d_reg, sda_d_reg;
   wire  scl_rise = scl_in & ~scl_d_reg;
   wire  scl_fall = ~scl_in & scl_d_reg;
   wire  start_c  = scl_in & scl_d_reg & sda_d_reg & ~sda_in;
   wire  stop_c   = scl_in & scl_d_reg & ~sda_d_reg & sda_in;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         scl_d_reg <= 1'b1;
         sda_d_reg <= 1'b1;
      end else begin
         scl_d_reg <= scl_in;
         sda_d_reg <= sda_in;
      end
   end

   // ----------------------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------------------
   logic [15:0]  scratch_reg, cfg_reg, high_reg, low_reg;
   logic         unlock_reg, strap_cap_reg;
   logic [6:0]   own_addr_reg;
   logic [7:0]   ptr_reg;
   logic [12:0]  busy_cnt_reg;
   snsid_state_t state_reg;
   logic [3:0]   bit_cnt_reg;
   logic [7:0]   shift_reg;
   logic         is_read_reg, first_byte_reg, have_msb_reg;
   logic         word_rdy_reg;   // lsb byte in, the word lands at its ack
   logic [7:0]   msb_reg;
   logic [15:0]  rd_word_reg;
   logic         rd_lo_reg;

   // read mux keyed by the current pointer
   function automatic logic [15:0] read_word(input logic [7:0] p);
      case (p)
         `SNSID_PTR_TEMP:     read_word = temp_result;
         `SNSID_PTR_CONFIG:   read_word = cfg_reg;
         `SNSID_PTR_HIGH_LIM: read_word = high_reg;
         `SNSID_PTR_LOW_LIM:  read_word = low_reg;
         `SNSID_PTR_UNLOCK:   read_word = {unlock_reg, busy_cnt_reg != 13'h0000, 14'h0000};
         `SNSID_PTR_SCRATCH4: read_word = scratch_reg;                            // RULE1
         `SNSID_PTR_PART_ID:  read_word = {4'h0, `SNSID_PART_CODE};                // RULE4
         default:             read_word = 16'h0000;
      endcase
   endfunction

   // strap caught after reset release; four addresses from the 2-bit address_strap_pin
   wire [6:0] strap_addr = {`SNSID_BASE_ADDR} | {5'h00, address_strap_pin};   // RULE8
   wire       addr_match = (shift_reg[7:1] == own_addr_reg);
   wire [7:0] rx_byte    = shift_reg;
   // a flag of its own: have_msb_reg alone cannot tell the pointer ack from the lsb ack
   wire       word_done  = word_rdy_reg;
   wire [15:0] wr_word   = {msb_reg, rx_byte};
   wire       wr_scratch = word_done && ptr_reg == `SNSID_PTR_SCRATCH4;
   wire       nvm_go     = wr_scratch & unlock_reg & (busy_cnt_reg == 13'h0000); // RULE3

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         strap_cap_reg <= 1'b0;
         own_addr_reg  <= 7'h00;
      end else if (!strap_cap_reg) begin
         strap_cap_reg <= 1'b1;
         own_addr_reg  <= strap_addr;                                            // RULE8
      end
   end

   // ----------------------------------------------------------------------------
   // two-wire target state machine; only ever pulls sda low, never scl
   // ----------------------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg      <= SNSID_IDLE;
         bit_cnt_reg    <= 4'h0;
         shift_reg      <= 8'h00;
         is_read_reg    <= 1'b0;
         first_byte_reg <= 1'b0;
         have_msb_reg   <= 1'b0;
         word_rdy_reg   <= 1'b0;
         msb_reg        <= 8'h00;
         rd_word_reg    <= 16'h0000;
         rd_lo_reg      <= 1'b0;
         sda_oe         <= 1'b0;
      end else if (start_c) begin
         state_reg    <= SNSID_ADDR;
         bit_cnt_reg  <= 4'h0;
         sda_oe       <= 1'b0;
         word_rdy_reg <= 1'b0;
      end else if (stop_c) begin
         state_reg    <= SNSID_IDLE;
         sda_oe       <= 1'b0;
         word_rdy_reg <= 1'b0;
      end else begin
         case (state_reg)
            SNSID_IDLE: sda_oe <= 1'b0;
            SNSID_ADDR, SNSID_WRX: begin
               if (scl_rise) begin
                  shift_reg   <= {shift_reg[6:0], sda_in};
                  bit_cnt_reg <= bit_cnt_reg + 4'h1;
               end
               if (scl_fall && bit_cnt_reg == 4'h8) begin
                  bit_cnt_reg <= 4'h0;
                  if (state_reg == SNSID_ADDR) begin
                     if (addr_match) begin                                      // RULE6
                        is_read_reg    <= shift_reg[0];
                        first_byte_reg <= 1'b1;
                        have_msb_reg   <= 1'b0;
                        rd_word_reg    <= read_word(ptr_reg);
                        rd_lo_reg      <= 1'b0;
                        sda_oe         <= 1'b1;
                        state_reg      <= SNSID_ACK;
                     end else begin
                        state_reg <= SNSID_IDLE;
                     end
                  end else begin
                     // every data byte is acked, part code writes too
                     sda_oe    <= 1'b1;                                         // RULE5
                     state_reg <= SNSID_ACK;
                     if (first_byte_reg) begin
                        first_byte_reg <= 1'b0;
                     end else if (!have_msb_reg) begin
                        have_msb_reg <= 1'b1;
                        msb_reg      <= rx_byte;
                     end else begin
                        have_msb_reg <= 1'b0;
                        word_rdy_reg <= 1'b1;
                     end
                  end
               end
            end
            SNSID_ACK: begin
               if (scl_fall) begin
                  // the word was written on this edge, so the flag is spent
                  word_rdy_reg <= 1'b0;
                  if (is_read_reg) begin
                     sda_oe    <= ~rd_word_reg[15];
                     state_reg <= SNSID_RDX;
                  end else begin
                     sda_oe    <= 1'b0;
                     state_reg <= SNSID_WRX;
                  end
                  rd_word_reg <= is_read_reg ? {rd_word_reg[14:0], 1'b0} : rd_word_reg;
                  bit_cnt_reg <= is_read_reg ? 4'h1 : 4'h0;
               end
            end
            SNSID_RDX: begin
               if (scl_fall) begin
                  if (bit_cnt_reg == 4'h8) begin
                     sda_oe    <= 1'b0;
                     state_reg <= SNSID_RACK;
                  end else begin
                     sda_oe      <= ~rd_word_reg[15];
                     rd_word_reg <= {rd_word_reg[14:0], 1'b0};
                     bit_cnt_reg <= bit_cnt_reg + 4'h1;
                  end
               end
            end
            SNSID_RACK: begin
               if (scl_rise) begin
                  // host nack ends the read; ack wraps to next byte of the word
                  if (sda_in) begin
                     state_reg <= SNSID_IDLE;
                  end else begin
                     rd_lo_reg <= ~rd_lo_reg;
                     if (rd_lo_reg) rd_word_reg <= read_word(ptr_reg);
                     state_reg <= SNSID_ACK;
                     is_read_reg <= 1'b1;
                  end
               end
            end
            default: state_reg <= SNSID_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------------------
   // pointer and register writes
   // ----------------------------------------------------------------------------
   wire ptr_load = (state_reg == SNSID_WRX) && scl_fall && bit_cnt_reg == 4'h8 && first_byte_reg;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ptr_reg    <= 8'h00;
         cfg_reg    <= `SNSID_CFG_RESET;
         high_reg   <= `SNSID_HIGH_RESET;
         low_reg    <= `SNSID_LOW_RESET;
         unlock_reg <= 1'b0;
      end else if (ptr_load) begin
         ptr_reg <= rx_byte;
      end else if (word_done && state_reg == SNSID_ACK && scl_fall) begin
         case (ptr_reg)
            `SNSID_PTR_CONFIG:   cfg_reg    <= wr_word;                          // RULE11
            `SNSID_PTR_HIGH_LIM: high_reg   <= wr_word;                          // RULE10
            `SNSID_PTR_LOW_LIM:  low_reg    <= wr_word;                          // RULE10
            `SNSID_PTR_UNLOCK:   unlock_reg <= wr_word[`SNSID_UNLOCK_BIT];
            default: ;                                                           // RULE5
         endcase
      end
   end

   // scratch: nvm copy loaded on request, host writes land in the register
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         scratch_reg <= 16'h0000;
      end else if (nvm_load) begin
         scratch_reg <= nvm_scratch_data;                                        // RULE2
      end else if (wr_scratch && state_reg == SNSID_ACK && scl_fall) begin
         scratch_reg <= wr_word;                                                 // RULE1
      end
   end

   // programming pulse and busy window; locked writes never reach the store
   wire prog_fire = nvm_go && state_reg == SNSID_ACK && scl_fall;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         nvm_prog      <= 1'b0;
         nvm_prog_data <= 16'h0000;
         busy_cnt_reg  <= 13'h0000;
      end else begin
         nvm_prog <= prog_fire;                                                  // RULE3
         if (prog_fire) begin
            nvm_prog_data <= wr_word;
            busy_cnt_reg  <= 13'(`SNSID_NVM_PROG_CYC);
         end else if (busy_cnt_reg != 13'h0000) begin
            busy_cnt_reg <= busy_cnt_reg - 13'h0001;
         end
      end
   end

   // ----------------------------------------------------------------------------
   // alarm and averaging outputs
   // ----------------------------------------------------------------------------
   wire above = $signed(temp_result) > $signed(high_reg);                        // RULE10
   wire below = $signed(temp_result) < $signed(low_reg);
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         alarm_n <= 1'b1;
         avg_sel <= 2'b01;
         sda_out <= 1'b0;
      end else begin
         if (temp_valid) alarm_n <= ~(above | below);                            // RULE9
         avg_sel <= cfg_reg[`SNSID_AVG_LSB +: 2];                                 // RULE11
         sda_out <= 1'b0;                                                        // RULE7
      end
   end
endmodule : snsid_regs
`default_nettype wire

// ==== verification/snsid_regs_monitor.sv ====
// snsid_regs_monitor.sv: port checker for the sensor register bank
// assumes: bound to snsid_regs; limit registers keep their reset values
`timescale 1ns/1ps
`default_nettype none
module snsid_regs_monitor (
   input wire logic        clk,
   input wire logic        arst_n,
   input wire logic        scl_in,
   input wire logic        sda_out,
   input wire logic        sda_oe,
   input wire logic [15:0] temp_result,
   input wire logic        temp_valid,
   input wire logic        nvm_prog,
   input wire logic [1:0]  avg_sel,
   input wire logic        alarm_n
);
   // ------------
   // assertions
   // ------------
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   logic [9:0] gap_reg;
   logic       hot;
   // cycles since the last program pulse, saturating so a long idle never wraps
   always_ff @(posedge clk or negedge arst_n)
      if (!arst_n) gap_reg <= 10'h3ff;
      else if (nvm_prog) gap_reg <= 10'h000;
      else if (gap_reg != 10'h3ff) gap_reg <= gap_reg + 10'h001;
   // above the high limit as it comes out of reset
   assign hot = $signed(temp_result) > $signed(16'h6000);
   sequence s_pulse;
      nvm_prog ##1 !nvm_prog;
   endsequence
   AST_SDA_LOW_ONLY: assert property (sda_out == 1'b0) else $error("sda driven high");
   AST_ACK_SCL_LOW: assert property ($rose(sda_oe) |-> !scl_in) else $error("sda moved, scl high");
   AST_OE_STANDS: assert property (sda_oe && scl_in |=> sda_oe) else $error("sda let go early");
   AST_PROG_PULSE: assert property (nvm_prog |-> s_pulse) else $error("program pulse too long");
   AST_PROG_AFTER_ACK: assert property (nvm_prog |-> $past(sda_oe) || $past(sda_oe, 2))
      else $error("program without ack");
   AST_PROG_GAP: assert property (nvm_prog |-> gap_reg >= 10'd874) else $error("program while busy");
   AST_ALARM_CAUSE: assert property (!$stable(alarm_n) |-> $past(temp_valid) || $past(temp_valid, 2))
      else $error("alarm moved alone");
   AST_ALARM_HOT: assert property (temp_valid && hot |-> ##[1:2] !alarm_n) else $error("alarm missed");
   AST_ALARM_OK: assert property (temp_valid && !hot && temp_result != 16'h8000 |-> ##[1:2] alarm_n)
      else $error("false alarm");
   AST_AVG_RESET: assert property ($rose(arst_n) |-> avg_sel == 2'b01) else $error("avg reset");
endmodule : snsid_regs_monitor
bind snsid_regs snsid_regs_monitor i_mon (.clk, .arst_n, .scl_in, .sda_out, .sda_oe, .temp_result,
   .temp_valid, .nvm_prog, .avg_sel, .alarm_n);
`default_nettype wire

// ==== verification/snsid_host.sv ====
// snsid_host.sv: behavioural two-wire bus controller facing the sensor bank
// assumes: sda is the resolved wired-and line with a pull-up
`timescale 1ns/1ps
`default_nettype none
module snsid_host (
   input  wire logic clk,
   input  wire logic sda,
   output logic      scl,
   output logic      sda_h
);
   // ------------
   // bus phases
   // ------------
   initial begin
      scl = 1'b1;
      sda_h = 1'b1;
   end
   // third of a bit, 4 clk: room for the 1-2 clk answer latency of the target
   task automatic ph(input logic c, input logic d);
      @(negedge clk);
      scl = c;
      sda_h = d;
      repeat (3) @(negedge clk);
   endtask : ph
   task automatic start();
      ph(1'b0, 1'b1);
      ph(1'b1, 1'b1);
      ph(1'b1, 1'b0);
      ph(1'b0, 1'b0);
   endtask : start
   task automatic stop();
      ph(1'b0, 1'b0);
      ph(1'b1, 1'b0);
      ph(1'b1, 1'b1);
   endtask : stop
   // eight bits then the ack bit; a 1 releases the line so the target can drive
   task automatic xbyte(input logic [7:0] w, input logic ak, output logic [7:0] r, output logic na);
      logic [8:0] v;
      logic [8:0] q;
      v = {w, ak};
      for (int i = 8; i >= 0; i--) begin
         ph(1'b0, v[i]);
         ph(1'b1, v[i]);
         q[i] = sda;
         ph(1'b0, v[i]);
      end
      r = q[8:1];
      na = q[0];
   endtask : xbyte
endmodule : snsid_host
`default_nettype wire

// ==== verification/snsid_regs_test.sv ====
// snsid_regs_test.sv: self-checking bench for the sensor register bank
// assumes: design, host model and monitor bind compiled before this file
`timescale 1ns/1ps
`default_nettype none
`include "snsid_params.svh"
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin fails++; \
   $display("CHECK FAILED t=%0t got %h exp %h", $time, a, e); end end
module snsid_regs_test;
   logic        clk, arst_n, sda, scl, sda_h, sda_out, sda_oe, temp_valid, nvm_load, nvm_prog, alarm_n, na;
   logic [1:0]  strap, avg_sel;
   logic [6:0]  dev;
   logic [15:0] temp_result, nvm_scratch_data, nvm_prog_data, pdata, rv, d;
   logic [15:0] mdl [int];
   int          fails, num_checks, progs, p0;
   // ------------
   // harness
   // ------------
   assign sda = sda_h & (sda_oe ? sda_out : 1'b1);
   assign dev = `SNSID_BASE_ADDR | {5'h00, strap};
   snsid_regs i_dut (.clk, .arst_n, .scl_in(scl), .sda_in(sda), .sda_out, .sda_oe, .address_strap_pin(strap),
      .temp_result, .temp_valid, .nvm_scratch_data, .nvm_load, .nvm_prog, .nvm_prog_data, .avg_sel, .alarm_n);
   snsid_host i_host (.clk, .sda, .scl, .sda_h);
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // catch program pulses, they last a single cycle
   always @(negedge clk) begin
      if (nvm_prog === 1'b1) begin
         progs++;
         pdata = nvm_prog_data;
      end
   end
   task automatic report_and_stop();
      $display("checks %0d fails %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : report_and_stop
   // pointer write, then a word if w is set; the model skips the read-only code
   task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [15:0] v, input logic w);
      logic [7:0] r;
      i_host.start();
      i_host.xbyte({a, 1'b0}, 1'b1, r, na);
      if (!na && w) begin
         i_host.xbyte(p, 1'b1, r, na);
         i_host.xbyte(v[15:8], 1'b1, r, na);
         i_host.xbyte(v[7:0], 1'b1, r, na);
         if (p != 8'h0f) mdl[p] = v;
      end else if (!na) begin
         i_host.xbyte(p, 1'b1, r, na);
      end
      i_host.stop();
   endtask : wr
   task automatic rd(input logic [7:0] p);
      logic [7:0] r;
      wr(dev, p, 16'h0000, 1'b0);
      i_host.start();
      i_host.xbyte({dev, 1'b1}, 1'b1, r, na);
      i_host.xbyte(8'hff, 1'b0, rv[15:8], na);
      i_host.xbyte(8'hff, 1'b1, rv[7:0], na);
      i_host.stop();
   endtask : rd
   // ------------
   // tests
   // ------------
   initial begin
      repeat (100000) @(posedge clk);
      fails++;
      report_and_stop();
   end
   initial begin
      {arst_n, strap, temp_valid, nvm_load, temp_result, nvm_scratch_data} = '0;
      void'($urandom(32'h36f0_6918));
      for (int s = 0; s < 4; s++) begin
         arst_n = 1'b0;
         strap = s[1:0];
         repeat (12) @(negedge clk);
         arst_n = 1'b1;
         repeat (4) @(negedge clk);
         wr(dev ^ 7'h01, 8'h08, 16'h0000, 1'b0);
         `CHK(na, 1'b1)
         wr(dev, 8'h08, 16'($urandom), 1'b1);
         `CHK(na, 1'b0)
         rd(8'h08);
         `CHK(rv, mdl[8])
      end
      $display("test strap and scratch done");
      nvm_scratch_data = 16'($urandom);
      nvm_load = 1'b1;
      mdl[8] = nvm_scratch_data;
      @(negedge clk);
      nvm_load = 1'b0;
      rd(8'h08);
      `CHK(rv, mdl[8])
      p0 = progs;
      wr(dev, 8'h08, 16'($urandom), 1'b1);
      `CHK(progs, p0)
      wr(dev, 8'h04, 16'h8000, 1'b1);
      d = 16'($urandom);
      wr(dev, 8'h08, d, 1'b1);
      `CHK(progs, p0 + 1)
      `CHK(pdata, d)
      // second write lands inside the busy window: register only, no new pulse
      wr(dev, 8'h08, ~d, 1'b1);
      `CHK(progs, p0 + 1)
      rd(8'h04);
      `CHK(rv, 16'hc000)
      repeat (900) @(negedge clk);
      d = 16'($urandom);
      wr(dev, 8'h08, d, 1'b1);
      `CHK(progs, p0 + 2)
      `CHK(pdata, d)
      wr(dev, 8'h04, 16'h0000, 1'b1);
      rd(8'h08);
      `CHK(rv, mdl[8])
      $display("test backing store done");
      rd(8'h0f);
      `CHK(rv[11:0], `SNSID_PART_CODE)
      wr(dev, 8'h0f, ~rv, 1'b1);
      `CHK(na, 1'b0)
      rd(8'h0f);
      `CHK(rv[11:0], `SNSID_PART_CODE)
      $display("test part code done");
      for (int a = 0; a < 4; a++) begin
         wr(dev, 8'h01, 16'h0200 | 16'(a << 5), 1'b1);
         `CHK(avg_sel, a[1:0])
      end
      $display("test averaging done");
      foreach (mdl[k]) p0 = k;
      for (int i = 0; i < 4; i++) begin
         d = i[0] ? 16'h6001 + 16'(i) : 16'($urandom) & 16'h5fff;
         temp_result = i == 3 ? 16'hf000 : d;
         temp_valid = 1'b1;
         @(negedge clk);
         temp_valid = 1'b0;
         repeat (3) @(negedge clk);
         `CHK(alarm_n, ($signed(temp_result) > $signed(16'h6000)) ? 1'b0 : 1'b1)
      end
      $display("test alarm done");
      report_and_stop();
   end
endmodule : snsid_regs_test
`default_nettype wire
